/* hw/cis_core_irq.v */
/*
  Core interrupt status/enable register with source flags, gates, vector
  request and a small event-interrupt bank, reached over classic Wishbone.
  Assumes pins arrive asynchronously, timer overflow and peripheral flags
  come from logic on clk_i, and the core sequencer pulses vec_taken_i.
*/
// Notes on behaviour
// - Bit 7 reads the OR over peripheral sources of each flag ANDed with its enable.
// - Bit 6 sets when the selected edge appears on the timer clock pin.
// - Bit 6 clears when the core vectors to address 18h.
// - Bit 5 sets whenever timer zero overflows.
// - Bit 5 clears when the core vectors to address 10h.
// - Bit 4 sets when the selected edge appears on the external interrupt pin.
// - Bit 4 clears when the core vectors to address 08h.
// - Bit 3 gates all peripheral requests.
// - Bit 2 gates the timer clock pin edge request.
// - Bit 1 gates the timer zero overflow request.
// - Bit 0 gates the external pin edge request.
// - Bit 7 is pure combinational reduction with no storage of its own.
// - Flags set on their condition regardless of enables or the global disable.
// - A flag set in the cycle its enable is cleared, with interrupts on, vectors to 00h.
`include "cis_defs.vh"
`default_nettype none

module cis_core_irq #(
  parameter NUM_PERIPH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire timer_clock_input_pin_i,
  input wire external_irq_pin_i,
  input wire tclk_rising_sel_i,
  input wire ext_rising_sel_i,
  input wire timer_zero_ovf_i,
  input wire [NUM_PERIPH-1:0] periph_flag_register_i,
  input wire [NUM_PERIPH-1:0] periph_enable_i,
  input wire global_irq_disable_i,
  input wire vec_taken_i,
  input wire [7:0] vec_addr_i,
  output reg vec_req_o,
  output reg [7:0] vec_addr_o,
  output reg [7:0] status_control_o,
  output reg irq_o
);

  // ==========================================================================
  // pin synchronisers and edge detection
  reg [1:0] tclk_sync_reg;
  reg [1:0] ext_sync_reg;
  reg tclk_prev_reg;
  reg ext_prev_reg;
  reg [1:0] arm_cnt_reg;
  wire edge_arm;
  wire tclk_edge;
  wire ext_edge;

  // the flops restart at 0 whatever the pin idles at; edges stay masked
  // until the chain and the history flop both hold real pin levels
  assign edge_arm = (arm_cnt_reg == 2'h3);

  always @(posedge clk_i) begin
    if (rst_i) begin
      tclk_sync_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
      tclk_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      arm_cnt_reg <= 2'h0;
    end else begin
      if (!edge_arm) begin
        arm_cnt_reg <= arm_cnt_reg + 2'h1;
      end
      tclk_sync_reg <= {tclk_sync_reg[0], timer_clock_input_pin_i};
      ext_sync_reg <= {ext_sync_reg[0], external_irq_pin_i};
      tclk_prev_reg <= tclk_sync_reg[1];
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // polarity select: 1 = rising, 0 = falling
  assign tclk_edge = edge_arm & (tclk_rising_sel_i ? (tclk_sync_reg[1] & ~tclk_prev_reg) :
                     (~tclk_sync_reg[1] & tclk_prev_reg));
  assign ext_edge = edge_arm & (ext_rising_sel_i ? (ext_sync_reg[1] & ~ext_prev_reg) :
                    (~ext_sync_reg[1] & ext_prev_reg));

  // ==========================================================================
  // flags and gates
  reg tclk_pin_edge_flag_reg;
  reg timer_zero_ovf_flag_reg;
  reg ext_pin_edge_flag_reg;
  reg [3:0] gate_reg;
  reg [3:0] gate_next;
  wire periph_pending_flag;
  wire bus_wr;
  wire bus_rd;
  wire wr_ctrl;
  wire clr_tclk;
  wire clr_tzero;
  wire clr_ext;

  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign bus_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign wr_ctrl = bus_wr & wb_sel_i[0] & (wb_adr_i == `CIS_OFF_STATUS_CONTROL);

  // combinational reduction only, nothing stored
  assign periph_pending_flag = |(periph_flag_register_i & periph_enable_i);

  assign clr_tclk = vec_taken_i & (vec_addr_i == `CIS_VEC_TCLK);
  assign clr_tzero = vec_taken_i & (vec_addr_i == `CIS_VEC_TZERO);
  assign clr_ext = vec_taken_i & (vec_addr_i == `CIS_VEC_EXT);

  always @* begin
    gate_next = gate_reg;
    if (wr_ctrl) begin
      gate_next = wb_dat_i[3:0];
    end
  end

  // set wins over both vector clear and software write of zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      tclk_pin_edge_flag_reg <= 1'b0;
      timer_zero_ovf_flag_reg <= 1'b0;
      ext_pin_edge_flag_reg <= 1'b0;
      gate_reg <= 4'h0;
    end else begin
      gate_reg <= gate_next;
      if (tclk_edge) begin
        tclk_pin_edge_flag_reg <= 1'b1;
      end else if (clr_tclk) begin
        tclk_pin_edge_flag_reg <= 1'b0;
      end else if (wr_ctrl) begin
        tclk_pin_edge_flag_reg <= wb_dat_i[`CIS_BIT_TCLK_FLAG];
      end
      if (timer_zero_ovf_i) begin
        timer_zero_ovf_flag_reg <= 1'b1;
      end else if (clr_tzero) begin
        timer_zero_ovf_flag_reg <= 1'b0;
      end else if (wr_ctrl) begin
        timer_zero_ovf_flag_reg <= wb_dat_i[`CIS_BIT_TZERO_FLAG];
      end
      if (ext_edge) begin
        ext_pin_edge_flag_reg <= 1'b1;
      end else if (clr_ext) begin
        ext_pin_edge_flag_reg <= 1'b0;
      end else if (wr_ctrl) begin
        ext_pin_edge_flag_reg <= wb_dat_i[`CIS_BIT_EXT_FLAG];
      end
    end
  end

  wire [7:0] ctrl_word;
  assign ctrl_word = {periph_pending_flag, tclk_pin_edge_flag_reg, timer_zero_ovf_flag_reg,
                      ext_pin_edge_flag_reg, gate_reg};

  // ==========================================================================
  // vector request with priority ext > tzero > tclk > periph
  wire req_ext;
  wire req_tzero;
  wire req_tclk;
  wire req_periph;
  wire hazard;
  reg [7:0] vec_next;
  reg req_next;

  assign req_ext = ext_pin_edge_flag_reg & gate_reg[`CIS_BIT_EXT_GATE];
  assign req_tzero = timer_zero_ovf_flag_reg & gate_reg[`CIS_BIT_TZERO_GATE];
  assign req_tclk = tclk_pin_edge_flag_reg & gate_reg[`CIS_BIT_TCLK_GATE];
  assign req_periph = periph_pending_flag & gate_reg[`CIS_BIT_PERIPH_GATE];

  // enable dropped while its flag is being set with interrupts on; the
  // sequencer may also have latched the old enable, so reset vector is the safe answer
  assign hazard = ~global_irq_disable_i & wr_ctrl & (
    (gate_reg[`CIS_BIT_EXT_GATE] & ~wb_dat_i[`CIS_BIT_EXT_GATE] & ext_edge) |
    (gate_reg[`CIS_BIT_TZERO_GATE] & ~wb_dat_i[`CIS_BIT_TZERO_GATE] & timer_zero_ovf_i) |
    (gate_reg[`CIS_BIT_TCLK_GATE] & ~wb_dat_i[`CIS_BIT_TCLK_GATE] & tclk_edge) |
    (gate_reg[`CIS_BIT_PERIPH_GATE] & ~wb_dat_i[`CIS_BIT_PERIPH_GATE] &
     periph_pending_flag));

  always @* begin
    req_next = 1'b0;
    vec_next = `CIS_VEC_RESET;
    if (hazard) begin
      req_next = 1'b1;
      vec_next = `CIS_VEC_RESET;
    end else if (!global_irq_disable_i) begin
      if (req_ext) begin
        req_next = 1'b1;
        vec_next = `CIS_VEC_EXT;
      end else if (req_tzero) begin
        req_next = 1'b1;
        vec_next = `CIS_VEC_TZERO;
      end else if (req_tclk) begin
        req_next = 1'b1;
        vec_next = `CIS_VEC_TCLK;
      end else if (req_periph) begin
        req_next = 1'b1;
        vec_next = `CIS_VEC_PERIPH;
      end
    end
  end

  // ==========================================================================
  // event status, enable and clear
  reg [`CIS_EVT_W-1:0] evt_status_reg;
  reg [`CIS_EVT_W-1:0] evt_enable_reg;
  wire [`CIS_EVT_W-1:0] evt_set;
  wire [`CIS_EVT_W-1:0] evt_clr;

  assign evt_set = {hazard, ext_edge, timer_zero_ovf_i, tclk_edge};
  assign evt_clr = (bus_wr & wb_sel_i[0] & (wb_adr_i == `CIS_OFF_EVT_CLEAR)) ?
                   wb_dat_i[`CIS_EVT_W-1:0] : {`CIS_EVT_W{1'b0}};

  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_reg <= {`CIS_EVT_W{1'b0}};
      evt_enable_reg <= {`CIS_EVT_W{1'b0}};
    end else begin
      evt_status_reg <= (evt_status_reg & ~evt_clr) | evt_set;
      if (bus_wr & wb_sel_i[0] & (wb_adr_i == `CIS_OFF_EVT_ENABLE)) begin
        evt_enable_reg <= wb_dat_i[`CIS_EVT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // bus read mux and registered outputs
  reg [31:0] rd_next;

  always @* begin
    rd_next = 32'h0000_0000;
    case (wb_adr_i)
      `CIS_OFF_STATUS_CONTROL: rd_next = {24'h000000, ctrl_word};
      `CIS_OFF_EVT_STATUS: rd_next = {28'h0000000, evt_status_reg};
      `CIS_OFF_EVT_ENABLE: rd_next = {28'h0000000, evt_enable_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      vec_req_o <= 1'b0;
      vec_addr_o <= `CIS_VEC_RESET;
      status_control_o <= `CIS_RESET_CTRL;
      irq_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_wr | bus_rd;
      wb_dat_o <= bus_rd ? rd_next : 32'h0000_0000;
      vec_req_o <= req_next;
      vec_addr_o <= vec_next;
      status_control_o <= ctrl_word;
      irq_o <= |(evt_status_reg & evt_enable_reg);
    end
  end

endmodule

`default_nettype wire

/* hw/cis_defs.vh */
/*
  Shared constants for the core interrupt status/enable block: register offsets,
  bit positions, reset values and vector addresses.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH

// ==========================================================================
// register offsets (byte addresses)
`define CIS_OFF_STATUS_CONTROL 4'h0
`define CIS_OFF_EVT_STATUS 4'h4
`define CIS_OFF_EVT_ENABLE 4'h8
`define CIS_OFF_EVT_CLEAR 4'hC

// ==========================================================================
// core_irq_status_control fields
`define CIS_BIT_PERIPH_FLAG 7
`define CIS_BIT_TCLK_FLAG 6
`define CIS_BIT_TZERO_FLAG 5
`define CIS_BIT_EXT_FLAG 4
`define CIS_BIT_PERIPH_GATE 3
`define CIS_BIT_TCLK_GATE 2
`define CIS_BIT_TZERO_GATE 1
`define CIS_BIT_EXT_GATE 0
`define CIS_RESET_CTRL 8'h00

// ==========================================================================
// vector addresses
`define CIS_VEC_RESET 8'h00
`define CIS_VEC_EXT 8'h08
`define CIS_VEC_TZERO 8'h10
`define CIS_VEC_TCLK 8'h18
`define CIS_VEC_PERIPH 8'h20

// ==========================================================================
// event status bits
`define CIS_EVT_TCLK 0
`define CIS_EVT_TZERO 1
`define CIS_EVT_EXT 2
`define CIS_EVT_HAZARD 3
`define CIS_EVT_W 4

`endif

/* tb/cis_core_irq_assertions.sv */
/* port checker for cis_core_irq
   bound from the bench top; sees only design ports */
`default_nettype none
module cis_core_irq_checker #(parameter NUM_PERIPH = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic timer_zero_ovf_i,
  input wire logic [NUM_PERIPH-1:0] periph_flag_register_i,
  input wire logic [NUM_PERIPH-1:0] periph_enable_i,
  input wire logic vec_taken_i,
  input wire logic [7:0] vec_addr_i,
  input wire logic vec_req_o,
  input wire logic [7:0] vec_addr_o,
  input wire logic [7:0] status_control_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // timing relations
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  // flag output is a copy one edge behind its combinational reduction
  property p_periph; !$past(rst_i) |->
    status_control_o[7] == $past(|(periph_flag_register_i & periph_enable_i)); endproperty
  a_periph: assert property (p_periph) else $error("periph flag");
  property p_tz_set; timer_zero_ovf_i |-> ##2 status_control_o[5]; endproperty
  a_tz_set: assert property (p_tz_set) else $error("overflow flag");
  property p_tz_clr; vec_taken_i && vec_addr_i == 8'h10 && !timer_zero_ovf_i && !wb_stb_i
    |-> ##2 !status_control_o[5]; endproperty
  a_tz_clr: assert property (p_tz_clr) else $error("overflow clear");
  property p_ext_clr; vec_taken_i && vec_addr_i == 8'h08 && !wb_stb_i
    |-> ##2 !status_control_o[4]; endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext clear");
  property p_tc_clr; vec_taken_i && vec_addr_i == 8'h18 && !wb_stb_i
    |-> ##2 !status_control_o[6]; endproperty
  a_tc_clr: assert property (p_tc_clr) else $error("tclk clear");
  property p_ext_gate; vec_req_o && vec_addr_o == 8'h08
    |-> status_control_o[4] && status_control_o[0]; endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("ext gate");
  c_tz: cover property (vec_taken_i && vec_addr_i == 8'h10);
  c_hazard: cover property (vec_req_o && vec_addr_o == 8'h00);
  c_periph: cover property (wb_ack_o && status_control_o[7]);
endmodule
`default_nettype wire

/* tb/cis_core_model.sv */
/* core sequencer model: takes each vector request after dly_i cycles
   assumes registered vec_req/vec_addr and a one-cycle taken pulse */
`default_nettype none
module cis_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] dly_i,
  input wire logic vec_req_i,
  input wire logic [7:0] vec_addr_i,
  output logic vec_taken_o,
  output logic [7:0] vec_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  // ==========================================
  // vector acceptance
  // idle address inverts every cycle so a stale value never holds for two cycles running; only vec_taken_o marks it valid
  always @(posedge clk_i) begin
    vec_taken_o <= 1'b0;
    vec_addr_o <= ~vec_addr_o;
    if (rst_i) begin
      cnt <= 5'h00;
      vec_addr_o <= 8'h00;
    end else if (cnt == 5'h00) begin
      if (vec_req_i) cnt <= {1'b0, dly_i} + 5'h04;
    end else begin
      cnt <= cnt - 5'h01;
      // extra count covers the two-edge lag before the request drops
      if (cnt == 5'h04) begin
        vec_taken_o <= 1'b1;
        vec_addr_o <= vec_addr_i;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_core_irq_status_enable.sv */
/* self-checking bench for the core interrupt status/enable block
   drives bus, pins and overflow; a core model answers vectors */
`default_nettype none
module test_core_irq_status_enable;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ovf = 1'b0;
  logic tpin = 1'b1, epin = 1'b0, esel = 1'b1, tsel = 1'b0, gdis = 1'b1;
  logic [3:0] adr = 4'h0, dly = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o;
  logic [7:0] pf = 8'h00, pe = 8'h00, vaddr, vaddr_o, sc;
  logic wb_ack_o, taken, vreq, irq;
  logic [32:0] exq[$], note;
  int fails = 0, checks = 0, cyc_n = 0, seed = 32'h1CEF;
  cis_core_irq #(.NUM_PERIPH(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_clock_input_pin_i(tpin),
    .external_irq_pin_i(epin), .tclk_rising_sel_i(tsel), .ext_rising_sel_i(esel),
    .timer_zero_ovf_i(ovf), .periph_flag_register_i(pf), .periph_enable_i(pe),
    .global_irq_disable_i(gdis), .vec_taken_i(taken), .vec_addr_i(vaddr),
    .vec_req_o(vreq), .vec_addr_o(vaddr_o), .status_control_o(sc), .irq_o(irq));
  cis_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly), .vec_req_i(vreq),
    .vec_addr_i(vaddr_o), .vec_taken_o(taken), .vec_addr_o(vaddr));
  // ==========================================
  // tasks
  task automatic end_sim;
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // p pulses the overflow at the edge the request is taken
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic [32:0] e, input logic p);
    exq.push_back(e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    ovf <= p;
    @(posedge clk_i);
    ovf <= 1'b0;
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    bus(1'b0, a, 8'h00, {9'h100, 16'h0, v}, 1'b0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic p);
    bus(1'b1, a, v, 33'h0, p);
  endtask
  // level is looked at mid-cycle, away from the edge that launches it
  task automatic chk(input logic e);
    @(negedge clk_i);
    checks++;
    if (irq !== e) begin
      fails++;
      $display("unexpected %0t output level", $time);
    end
  endtask
  task automatic chk_req(input logic e);
    @(negedge clk_i);
    checks++;
    if (vreq !== e) begin
      fails++;
      $display("unexpected %0t output level", $time);
    end
  endtask
  task automatic chk_unused(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t output level", $time);
    end
  endtask
  // ==========================================
  // read monitor and timeout
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      fails++;
      end_sim();
    end
    if (wb_ack_o === 1'b1 && exq.size() > 0) begin
      note = exq.pop_front();
      checks += note[32];
      if (note[32] && wb_dat_o !== note[31:0]) begin
        fails++;
        $display("unexpected %0t read data %h", $time, wb_dat_o);
      end
    end
  end
  initial forever #4 clk_i = ~clk_i;
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    wr(4'h2, 8'hFF, 1'b1);
    rd(4'h2, 8'h00);
    rd(4'h0, 8'h20);
    rd(4'h4, 8'h02);
    chk(1'b0);
    wr(4'h8, 8'h02, 1'b0);
    chk(1'b1);
    wr(4'h8, 8'h00, 1'b0);
    chk(1'b0);
    wr(4'h8, 8'h02, 1'b0);
    wr(4'hC, 8'h02, 1'b0);
    chk(1'b0);
    epin <= 1'b1;
    tpin <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(4'h0, 8'h70);
    rd(4'h4, 8'h05);
    for (int i = 0; i < 6; i++) begin
      pf <= 8'($random(seed));
      pe <= 8'($random(seed));
      @(posedge clk_i);
      rd(4'h0, {|(pf & pe), 7'h70});
    end
    pf <= 8'h00;
    dly <= 4'($random(seed));
    gdis <= 1'b0;
    wr(4'h0, 8'h7F, 1'b0);
    repeat (100) @(posedge clk_i);
    rd(4'h0, 8'h0F);
    chk_req(1'b0);
    wr(4'hC, 8'h0F, 1'b0);
    // gates dropped with interrupts on, deliberately, as an overflow lands
    wr(4'h0, 8'h00, 1'b1);
    rd(4'h0, 8'h20);
    rd(4'h4, 8'h0A);
    end_sim();
  end
endmodule
bind cis_core_irq cis_core_irq_checker #(.NUM_PERIPH(NUM_PERIPH)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .timer_zero_ovf_i(timer_zero_ovf_i), .periph_flag_register_i(periph_flag_register_i),
  .periph_enable_i(periph_enable_i), .vec_taken_i(vec_taken_i), .vec_addr_i(vec_addr_i),
  .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .status_control_o(status_control_o));
`default_nettype wire
